// [logic/radio_mode_match_config.sv]
// Radio address match, ramp-up, idle transmit and power configuration bank
//
// Function
// - Eight enable bits, one per address entry, gate matching of that entry.
// - Ramp select: 0 default enable delay, 1 shorter fast delay.
// - Fast ramp-up: hardware does not enforce interframe spacing; software times turn-on.
// - Idle transmit field: 0 sends one, 1 sends zero, 2 sends carrier.
// - Power bit: 0 powers off, 1 powers on, reads 1 after reset.
// - Power off then on returns all logic and registers to reset values.
// - Each entry is a 32-bit base segment plus prefix, eight entries.
`timescale 1ns/100ps
module radio_mode_match_config #(
  parameter int N              = radio_cfg_pkg::ENTRY_N,
  parameter int RAMP_DEFAULT_CYC = 7,
  parameter int RAMP_FAST_CYC    = 2,
  parameter int IFS_CYC          = 7
) (
  input  wire logic                                 clk_sys,
  input  wire logic                                 resetn,
  input  wire logic [radio_cfg_pkg::ADDR_W-1:0]     reg_addr,
  input  wire logic [radio_cfg_pkg::DATA_W-1:0]     reg_wdata,
  input  wire logic                                 reg_wr,
  input  wire logic                                 reg_rd,
  output logic      [radio_cfg_pkg::DATA_W-1:0]     reg_rdata_q,
  input  wire logic                                 radio_enable_req,
  input  wire logic                                 frame_end,
  input  wire logic                                 tx_start,
  input  wire logic                                 tx_mode,
  input  wire logic                                 cmp_valid,
  input  wire logic [radio_cfg_pkg::DATA_W-1:0]     cmp_base,
  input  wire logic [radio_cfg_pkg::PREFIX_W-1:0]   cmp_prefix,
  output logic                                      radio_ready_q,
  output logic                                      peripheral_on_q,
  output logic                                      match_hit_q,
  output logic [$clog2(N)-1:0]                      match_idx_q,
  output logic                                      match_done_q,
  output radio_cfg_pkg::tx_out_e                    tx_out_q
);
  import radio_cfg_pkg::*;

  // ************************************************************
  // Register storage
  // ************************************************************
  logic [N-1:0][DATA_W-1:0]   base_q;
  logic [N-1:0][PREFIX_W-1:0] prefix_q;
  logic [N-1:0]               match_entry_enable_q;
  logic                       ramp_up_select_q;
  logic [1:0]                 idle_tx_value_q;
  logic                       power_q;
  logic                       power_prev_q;
  logic                       local_rst;
  logic                       hit_w;
  logic [$clog2(N)-1:0]       idx_w;
  logic                       done_w;
  logic [DATA_W-1:0]          last_base_q;
  logic [PREFIX_W-1:0]        last_pfx_q;

  function automatic logic in_range(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
    in_range = (a >= base) && (a < base + ADDR_W'(N * 4)) && (a[1:0] == 2'h0);
  endfunction : in_range

  function automatic logic [$clog2(N)-1:0] word_idx(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] diff;
    diff     = a - base;
    word_idx = diff[$clog2(N)+1:2];
  endfunction : word_idx

  // Power bit low is the local reset; the bank holds reset while off
  assign local_rst = !power_q;

  // ************************************************************
  // Power control
  // ************************************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      power_q <= RST_POWER[0];
    end else if (reg_wr && reg_addr == OFS_POWER) begin
      power_q <= reg_wdata[0];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      power_prev_q    <= RST_POWER[0];
      peripheral_on_q <= RST_POWER[0];
    end else begin
      power_prev_q    <= power_q;
      peripheral_on_q <= power_q;
    end
  end

  // ************************************************************
  // Address entries
  // ************************************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      base_q   <= '0;
      prefix_q <= '0;
    end else if (local_rst) begin
      base_q   <= '0;
      prefix_q <= '0;
    end else if (reg_wr) begin
      if (in_range(reg_addr, OFS_BASE0)) begin
        base_q[word_idx(reg_addr, OFS_BASE0)] <= reg_wdata;
      end
      if (in_range(reg_addr, OFS_PREFIX0)) begin
        prefix_q[word_idx(reg_addr, OFS_PREFIX0)] <= reg_wdata[PREFIX_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      match_entry_enable_q <= RST_MATCH_CFG[N-1:0];
    end else if (local_rst) begin
      match_entry_enable_q <= RST_MATCH_CFG[N-1:0];
    end else if (reg_wr && reg_addr == OFS_MATCH_CFG) begin
      match_entry_enable_q <= reg_wdata[N-1:0];
    end
  end

  // ************************************************************
  // Mode configuration
  // ************************************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ramp_up_select_q <= RST_MODE_CFG0[RAMP_BIT];
      idle_tx_value_q  <= RST_MODE_CFG0[IDLE_HI:IDLE_LO];
    end else if (local_rst) begin
      ramp_up_select_q <= RST_MODE_CFG0[RAMP_BIT];
      idle_tx_value_q  <= RST_MODE_CFG0[IDLE_HI:IDLE_LO];
    end else if (reg_wr && reg_addr == OFS_MODE_CFG0) begin
      ramp_up_select_q <= reg_wdata[RAMP_BIT];
      idle_tx_value_q  <= reg_wdata[IDLE_HI:IDLE_LO];
    end
  end

  // ************************************************************
  // Ramp-up timing and interframe spacing
  // ************************************************************
  typedef enum logic [1:0] {
    RS_OFF,
    RS_SPACING,
    RS_RAMP,
    RS_READY
  } ramp_state_e;

  ramp_state_e ramp_state_q;
  logic [7:0]  ramp_cnt_q;
  logic        tx_idle_w;

  // Spacing only applies in default ramp mode; fast mode trusts software timing
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ramp_state_q  <= RS_OFF;
      ramp_cnt_q    <= '0;
      radio_ready_q <= 1'b0;
    end else if (local_rst) begin
      ramp_state_q  <= RS_OFF;
      ramp_cnt_q    <= '0;
      radio_ready_q <= 1'b0;
    end else begin
      unique case (ramp_state_q)
        RS_OFF: begin
          radio_ready_q <= 1'b0;
          if (radio_enable_req) begin
            if (ramp_up_select_q) begin
              ramp_state_q <= RS_RAMP;
              ramp_cnt_q   <= 8'(RAMP_FAST_CYC - 1);
            end else begin
              ramp_state_q <= RS_RAMP;
              ramp_cnt_q   <= 8'(RAMP_DEFAULT_CYC - 1);
            end
          end
        end
        RS_SPACING: begin
          if (ramp_cnt_q == 8'h00) begin
            ramp_state_q <= RS_OFF;
          end else begin
            ramp_cnt_q <= ramp_cnt_q - 8'h01;
          end
        end
        RS_RAMP: begin
          if (ramp_cnt_q == 8'h00) begin
            ramp_state_q  <= RS_READY;
            radio_ready_q <= 1'b1;
          end else begin
            ramp_cnt_q <= ramp_cnt_q - 8'h01;
          end
        end
        RS_READY: begin
          if (frame_end && !radio_enable_req) begin
            radio_ready_q <= 1'b0;
            if (ramp_up_select_q) begin
              ramp_state_q <= RS_OFF;
            end else begin
              ramp_state_q <= RS_SPACING;
              ramp_cnt_q   <= 8'(IFS_CYC - 1);
            end
          end
        end
      endcase
    end
  end

  assign tx_idle_w = tx_mode && radio_ready_q && !tx_start;

  // ************************************************************
  // Submodules
  // ************************************************************
  address_matcher #(
    .N (N)
  ) u_matcher (
    .clk_sys      (clk_sys),
    .resetn       (resetn),
    .local_rst    (local_rst),
    .entry_enable (match_entry_enable_q),
    .base_seg     (base_q),
    .prefix_seg   (prefix_q),
    .cmp_valid    (cmp_valid),
    .cmp_base     (cmp_base),
    .cmp_prefix   (cmp_prefix),
    .hit_q        (hit_w),
    .hit_idx_q    (idx_w),
    .done_q       (done_w)
  );

  idle_tx_select u_idle (
    .clk_sys       (clk_sys),
    .resetn        (resetn),
    .local_rst     (local_rst),
    .tx_idle       (tx_idle_w),
    .idle_tx_value (idle_tx_value_q),
    .tx_out_q      (tx_out_q)
  );

  // Compare record cleared by a power cycle like every other register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      match_hit_q  <= 1'b0;
      match_idx_q  <= '0;
      match_done_q <= 1'b0;
      last_base_q  <= '0;
      last_pfx_q   <= '0;
    end else if (local_rst) begin
      match_hit_q  <= 1'b0;
      match_idx_q  <= '0;
      match_done_q <= 1'b0;
      last_base_q  <= '0;
      last_pfx_q   <= '0;
    end else begin
      match_hit_q  <= hit_w;
      match_idx_q  <= idx_w;
      match_done_q <= done_w;
      if (cmp_valid) begin
        last_base_q <= cmp_base;
        last_pfx_q  <= cmp_prefix;
      end
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  // Data stands one cycle only, so no stale word reaches the bus
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_q <= RST_ZERO;
    end else if (reg_rd) begin
      reg_rdata_q <= RST_ZERO;
      if (in_range(reg_addr, OFS_BASE0)) begin
        reg_rdata_q <= base_q[word_idx(reg_addr, OFS_BASE0)];
      end else if (in_range(reg_addr, OFS_PREFIX0)) begin
        reg_rdata_q[PREFIX_W-1:0] <= prefix_q[word_idx(reg_addr, OFS_PREFIX0)];
      end else begin
        unique case (reg_addr)
          OFS_MATCH_CFG:  reg_rdata_q[N-1:0] <= match_entry_enable_q;
          OFS_MODE_CFG0: begin
            reg_rdata_q[RAMP_BIT]        <= ramp_up_select_q;
            reg_rdata_q[IDLE_HI:IDLE_LO] <= idle_tx_value_q;
          end
          OFS_POWER:      reg_rdata_q[0] <= power_q;
          OFS_STATUS: begin
            reg_rdata_q[ST_HIT]              <= hit_w;
            reg_rdata_q[ST_IDX_HI:ST_IDX_LO] <= idx_w;
            reg_rdata_q[ST_FAST]             <= ramp_up_select_q;
          end
          OFS_MATCH_ADDR: reg_rdata_q <= last_base_q;
          OFS_MATCH_PFX:  reg_rdata_q[PREFIX_W-1:0] <= last_pfx_q;
          default:        reg_rdata_q <= RST_ZERO;
        endcase
      end
    end else begin
      reg_rdata_q <= RST_ZERO;
    end
  end

  // Edge kept for a future power-up event; off already holds everything in reset
  logic unused_prev;
  assign unused_prev = power_prev_q;
endmodule : radio_mode_match_config

// [shared/radio_cfg_pkg.sv]
// Register map, field layout and mode encodings of the radio configuration bank
package radio_cfg_pkg;
  localparam int ADDR_W       = 12;
  localparam int DATA_W       = 32;
  localparam int ENTRY_N      = 8;
  localparam int PREFIX_W     = 8;

  localparam logic [ADDR_W-1:0] OFS_BASE0      = 12'h600;
  localparam logic [ADDR_W-1:0] OFS_PREFIX0    = 12'h620;
  localparam logic [ADDR_W-1:0] OFS_MATCH_CFG  = 12'h640;
  localparam logic [ADDR_W-1:0] OFS_MODE_CFG0  = 12'h650;
  localparam logic [ADDR_W-1:0] OFS_POWER      = 12'hFFC;
  localparam logic [ADDR_W-1:0] OFS_STATUS     = 12'h660;
  localparam logic [ADDR_W-1:0] OFS_MATCH_ADDR = 12'h664;
  localparam logic [ADDR_W-1:0] OFS_MATCH_PFX  = 12'h668;

  localparam int RAMP_BIT     = 0;
  localparam int IDLE_LO      = 8;
  localparam int IDLE_HI      = 9;
  localparam int ST_HIT       = 0;
  localparam int ST_IDX_LO    = 1;
  localparam int ST_IDX_HI    = 3;
  localparam int ST_FAST      = 4;

  localparam logic [DATA_W-1:0] RST_MATCH_CFG = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_MODE_CFG0 = 32'h0000_0200;
  localparam logic [DATA_W-1:0] RST_POWER     = 32'h0000_0001;
  localparam logic [DATA_W-1:0] RST_ZERO      = 32'h0000_0000;

  localparam logic [1:0] IDLE_SEND_ONE   = 2'h0;
  localparam logic [1:0] IDLE_SEND_ZERO  = 2'h1;
  localparam logic [1:0] IDLE_CENTRE     = 2'h2;

  typedef enum logic [1:0] {
    TXO_NONE,
    TXO_ONE,
    TXO_ZERO,
    TXO_CARRIER
  } tx_out_e;
endpackage : radio_cfg_pkg

// [logic/address_matcher.sv]
// Compares a received address against the enabled base and prefix entries
`timescale 1ns/100ps
module address_matcher #(
  parameter int N = radio_cfg_pkg::ENTRY_N
) (
  input  wire logic                                 clk_sys,
  input  wire logic                                 resetn,
  input  wire logic                                 local_rst,
  input  wire logic [N-1:0]                         entry_enable,
  input  wire logic [N-1:0][radio_cfg_pkg::DATA_W-1:0]   base_seg,
  input  wire logic [N-1:0][radio_cfg_pkg::PREFIX_W-1:0] prefix_seg,
  input  wire logic                                 cmp_valid,
  input  wire logic [radio_cfg_pkg::DATA_W-1:0]     cmp_base,
  input  wire logic [radio_cfg_pkg::PREFIX_W-1:0]   cmp_prefix,
  output logic                                      hit_q,
  output logic [$clog2(N)-1:0]                      hit_idx_q,
  output logic                                      done_q
);
  import radio_cfg_pkg::*;

  logic                 hit_d;
  logic [$clog2(N)-1:0] idx_d;

  // Lowest enabled matching entry wins
  always_comb begin
    hit_d = 1'b0;
    idx_d = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (entry_enable[i] && base_seg[i] == cmp_base && prefix_seg[i] == cmp_prefix) begin
        hit_d = 1'b1;
        idx_d = $clog2(N)'(i);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hit_q     <= 1'b0;
      hit_idx_q <= '0;
      done_q    <= 1'b0;
    end else if (local_rst) begin
      hit_q     <= 1'b0;
      hit_idx_q <= '0;
      done_q    <= 1'b0;
    end else begin
      done_q <= cmp_valid;
      if (cmp_valid) begin
        hit_q     <= hit_d;
        hit_idx_q <= idx_d;
      end
    end
  end
endmodule : address_matcher

// [logic/idle_tx_select.sv]
// Chooses what the transmitter sends while ready but not started
`timescale 1ns/100ps
module idle_tx_select (
  input  wire logic                    clk_sys,
  input  wire logic                    resetn,
  input  wire logic                    local_rst,
  input  wire logic                    tx_idle,
  input  wire logic [1:0]              idle_tx_value,
  output radio_cfg_pkg::tx_out_e       tx_out_q
);
  import radio_cfg_pkg::*;

  tx_out_e tx_out_d;

  always_comb begin
    tx_out_d = TXO_NONE;
    if (tx_idle) begin
      unique case (idle_tx_value)
        IDLE_SEND_ONE:  tx_out_d = TXO_ONE;
        IDLE_SEND_ZERO: tx_out_d = TXO_ZERO;
        IDLE_CENTRE:    tx_out_d = TXO_CARRIER;
        default:        tx_out_d = TXO_CARRIER;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tx_out_q <= TXO_NONE;
    end else if (local_rst) begin
      tx_out_q <= TXO_NONE;
    end else begin
      tx_out_q <= tx_out_d;
    end
  end
endmodule : idle_tx_select

// [testbench/radio_mode_match_config_asserts.sv]
// Port-level assertions for the radio configuration bank
`timescale 1ns/100ps
module radio_mode_match_config_asserts #(
  parameter int N                = radio_cfg_pkg::ENTRY_N,
  parameter int RAMP_DEFAULT_CYC = 7,
  parameter int RAMP_FAST_CYC    = 2,
  parameter int IFS_CYC          = 7
) (
  input wire logic                               clk_sys,
  input wire logic                               resetn,
  input wire logic [radio_cfg_pkg::ADDR_W-1:0]   reg_addr,
  input wire logic [radio_cfg_pkg::DATA_W-1:0]   reg_wdata,
  input wire logic                               reg_wr,
  input wire logic                               reg_rd,
  input wire logic [radio_cfg_pkg::DATA_W-1:0]   reg_rdata_q,
  input wire logic                               radio_enable_req,
  input wire logic                               frame_end,
  input wire logic                               tx_start,
  input wire logic                               tx_mode,
  input wire logic                               cmp_valid,
  input wire logic [radio_cfg_pkg::DATA_W-1:0]   cmp_base,
  input wire logic [radio_cfg_pkg::PREFIX_W-1:0] cmp_prefix,
  input wire logic                               radio_ready_q,
  input wire logic                               peripheral_on_q,
  input wire logic                               match_hit_q,
  input wire logic [$clog2(N)-1:0]               match_idx_q,
  input wire logic                               match_done_q,
  input wire radio_cfg_pkg::tx_out_e             tx_out_q
);
  import radio_cfg_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ****************
  // Assertions
  // ****************
  a_done_delay: assert property (cmp_valid |-> ##2 match_done_q) else $error("match done late");
  a_done_cause: assert property (match_done_q |-> $past(cmp_valid, 2)) else $error("stray match done");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_q == '0) else $error("read data outside slot");
  a_ramp_time: assert property ($rose(radio_ready_q) |-> $past(radio_enable_req, RAMP_FAST_CYC + 1)
    || $past(radio_enable_req, RAMP_DEFAULT_CYC + 1)) else $error("ramp length wrong");
  a_tx_not_idle: assert property (!($past(tx_mode) && $past(radio_ready_q) && !$past(tx_start))
    |-> tx_out_q == TXO_NONE) else $error("idle value outside idle");
  a_tx_started: assert property (tx_start |=> tx_out_q == TXO_NONE) else $error("idle value while started");
  a_power_on: assert property (reg_wr && reg_addr == OFS_POWER && reg_wdata[0] |-> ##[1:2] peripheral_on_q)
    else $error("power on not seen");
  a_power_off: assert property (reg_wr && reg_addr == OFS_POWER && !reg_wdata[0] |-> ##[1:2] !peripheral_on_q)
    else $error("power off not seen");
  a_off_idle: assert property (!peripheral_on_q |-> !radio_ready_q && !match_done_q) else $error("active while off");
  // ****************
  // Coverage
  // ****************
  c_hit: cover property (match_done_q && match_hit_q);
  c_ready: cover property ($rose(radio_ready_q));
  c_carrier: cover property (tx_out_q == TXO_CARRIER);
endmodule : radio_mode_match_config_asserts

// [testbench/radio_mode_match_config_tb.sv]
// Self-checking bench for the radio configuration bank
`timescale 1ns/100ps
module radio_mode_match_config_tb;
  import radio_cfg_pkg::*;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic [11:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata_q;
  logic        radio_enable_req = 1'b0;
  logic        frame_end = 1'b0;
  logic        tx_start = 1'b0;
  logic        tx_mode = 1'b0;
  logic        cmp_valid = 1'b0;
  logic [31:0] cmp_base = '0;
  logic [7:0]  cmp_prefix = '0;
  logic        radio_ready_q, peripheral_on_q, match_hit_q, match_done_q;
  logic [2:0]  match_idx_q;
  tx_out_e     tx_out_q;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  localparam int RD = 7;
  localparam int RF = 2;
  localparam int IFS = 7;

  radio_mode_match_config #(.N(8), .RAMP_DEFAULT_CYC(RD), .RAMP_FAST_CYC(RF), .IFS_CYC(IFS)) u_dut (
    .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .radio_enable_req(radio_enable_req), .frame_end(frame_end),
    .tx_start(tx_start), .tx_mode(tx_mode), .cmp_valid(cmp_valid), .cmp_base(cmp_base),
    .cmp_prefix(cmp_prefix), .radio_ready_q(radio_ready_q), .peripheral_on_q(peripheral_on_q),
    .match_hit_q(match_hit_q), .match_idx_q(match_idx_q), .match_done_q(match_done_q), .tx_out_q(tx_out_q));

  always #10 clk_sys = ~clk_sys;
  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      $display("[FAIL] timeout exp finish got hang");
      tally_and_finish();
    end
  end
  // ****************
  // Shared tasks
  // ****************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("[FAIL] %s exp %h got %h", nm, e, g);
      mismatches++;
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(nm, e, reg_rdata_q);
  endtask : rd_chk
  // Counts from the edge that takes the request to the one that shows ready
  task automatic ramp(input string nm, input int e);
    int n;
    @(posedge clk_sys);
    radio_enable_req <= 1'b1;
    @(posedge clk_sys);
    radio_enable_req <= 1'b0;
    n = 1;
    while (n < 20) begin
      @(posedge clk_sys);
      #1;
      n++;
      if (radio_ready_q === 1'b1) break;
    end
    chk(nm, e, n);
  endtask : ramp
  task automatic end_pulse();
    @(posedge clk_sys);
    frame_end <= 1'b1;
    @(posedge clk_sys);
    frame_end <= 1'b0;
  endtask : end_pulse
  task automatic cmpt(input logic [31:0] b, input logic [7:0] p, input logic h, input logic [2:0] ix);
    int n;
    @(posedge clk_sys);
    cmp_valid <= 1'b1;
    cmp_base <= b;
    cmp_prefix <= p;
    @(posedge clk_sys);
    cmp_valid <= 1'b0;
    n = 0;
    while (n < 4 && match_done_q !== 1'b1) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk("match_done", 32'h1, 32'(match_done_q));
    chk("match_hit", 32'(h), 32'(match_hit_q));
    if (h) chk("match_idx", 32'(ix), 32'(match_idx_q));
  endtask : cmpt
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset();
    rd_chk("match_cfg", OFS_MATCH_CFG, RST_MATCH_CFG);
    rd_chk("mode_cfg", OFS_MODE_CFG0, RST_MODE_CFG0);
    rd_chk("power", OFS_POWER, RST_POWER);
    rd_chk("unmapped", 12'h700, RST_ZERO);
    chk("on_after_reset", 32'h1, 32'(peripheral_on_q));
    $display("test reset done");
  endtask : t_reset
  task automatic t_match();
    for (int i = 0; i < 8; i++) begin
      wr(OFS_BASE0 + 12'(4 * i), 32'hA5C3_0000 + i);
      wr(OFS_PREFIX0 + 12'(4 * i), 32'h40 + i);
    end
    wr(OFS_MATCH_CFG, 32'h0000_00A5);
    rd_chk("base5", OFS_BASE0 + 12'h014, 32'hA5C3_0005);
    rd_chk("prefix5", OFS_PREFIX0 + 12'h014, 32'h45);
    rd_chk("enables", OFS_MATCH_CFG, 32'h0000_00A5);
    for (int i = 0; i < 8; i++) cmpt(32'hA5C3_0000 + i, 8'(8'h40 + i), 1'(8'hA5 >> i), 3'(i));
    rd_chk("status", OFS_STATUS, 32'h0000_000F);
    rd_chk("last_base", OFS_MATCH_ADDR, 32'hA5C3_0007);
    rd_chk("last_pfx", OFS_MATCH_PFX, 32'h0000_0047);
    cmpt(32'hA5C3_0000, 8'h45, 1'b0, 3'h0);
    $display("test match done");
  endtask : t_match
  task automatic t_ramp();
    wr(OFS_MODE_CFG0, 32'h0000_0201);
    ramp("fast_ramp", RF + 1);
    end_pulse();
    @(posedge clk_sys);
    #1 chk("ready_drop", 32'h0, 32'(radio_ready_q));
    ramp("fast_no_spacing", RF + 1);
    wr(OFS_MODE_CFG0, 32'h0000_0200);
    end_pulse();
    @(posedge clk_sys);
    radio_enable_req <= 1'b1;
    @(posedge clk_sys);
    radio_enable_req <= 1'b0;
    repeat (RD + 4) @(posedge clk_sys);
    #1 chk("spacing_refuse", 32'h0, 32'(radio_ready_q));
    ramp("default_ramp", RD + 1);
    $display("test ramp done");
  endtask : t_ramp
  task automatic t_idle();
    tx_out_e e[4];
    e = '{TXO_ONE, TXO_ZERO, TXO_CARRIER, TXO_CARRIER};
    @(posedge clk_sys);
    tx_mode <= 1'b1;
    // Centre setting first, as crystal tuning needs it
    wr(OFS_MODE_CFG0, 32'(IDLE_CENTRE) << IDLE_LO);
    repeat (2) @(posedge clk_sys);
    #1 chk("tune_carrier", 32'(TXO_CARRIER), 32'(tx_out_q));
    for (int c = 0; c < 4; c++) begin
      wr(OFS_MODE_CFG0, 32'(c) << 8);
      repeat (2) @(posedge clk_sys);
      #1 chk("idle_tx", 32'(e[c]), 32'(tx_out_q));
    end
    @(posedge clk_sys);
    tx_start <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 chk("started_tx", 32'(TXO_NONE), 32'(tx_out_q));
    @(posedge clk_sys);
    tx_start <= 1'b0;
    tx_mode <= 1'b0;
    $display("test idle done");
  endtask : t_idle
  task automatic t_power();
    wr(OFS_MATCH_CFG, 32'h0000_00FF);
    cmpt(32'hA5C3_0000, 8'h40, 1'b1, 3'h0);
    wr(OFS_POWER, 32'h0);
    @(posedge clk_sys);
    #1 chk("on_off", 32'h0, 32'(peripheral_on_q));
    rd_chk("power_off", OFS_POWER, 32'h0);
    wr(OFS_MATCH_CFG, 32'h0000_000F);
    wr(OFS_POWER, 32'h1);
    rd_chk("power_back", OFS_POWER, RST_POWER);
    rd_chk("match_cycled", OFS_MATCH_CFG, RST_MATCH_CFG);
    rd_chk("mode_cycled", OFS_MODE_CFG0, RST_MODE_CFG0);
    rd_chk("base_cycled", OFS_BASE0, RST_ZERO);
    rd_chk("last_cycled", OFS_MATCH_ADDR, RST_ZERO);
    chk("on_back", 32'h1, 32'(peripheral_on_q));
    chk("ready_cycled", 32'h0, 32'(radio_ready_q));
    chk("hit_cycled", 32'h0, 32'(match_hit_q));
    $display("test power done");
  endtask : t_power
  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset();
    t_match();
    t_ramp();
    t_idle();
    t_power();
    tally_and_finish();
  end
endmodule : radio_mode_match_config_tb

bind radio_mode_match_config radio_mode_match_config_asserts #(.N(N), .RAMP_DEFAULT_CYC(RAMP_DEFAULT_CYC),
  .RAMP_FAST_CYC(RAMP_FAST_CYC), .IFS_CYC(IFS_CYC)) u_chk (.clk_sys(clk_sys), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
  .radio_enable_req(radio_enable_req), .frame_end(frame_end), .tx_start(tx_start), .tx_mode(tx_mode),
  .cmp_valid(cmp_valid), .cmp_base(cmp_base), .cmp_prefix(cmp_prefix), .radio_ready_q(radio_ready_q),
  .peripheral_on_q(peripheral_on_q), .match_hit_q(match_hit_q), .match_idx_q(match_idx_q),
  .match_done_q(match_done_q), .tx_out_q(tx_out_q));
